// [rtl/xps_map.svh]
`ifndef XPS_MAP_SVH
`define XPS_MAP_SVH
// ==========================================================
// register addresses
`define XPS_ADDR_ROUTE 8'h00
`define XPS_ADDR_CTRL 8'h03
`define XPS_ADDR_STATUS 8'h04
// ==========================================================
// reset values
`define XPS_ROUTE_RESET 8'h00
`define XPS_CTRL_RESET 8'h0f
`define XPS_STATUS_RESET 4'h0
`define XPS_RSVD_READ 4'h0
`define XPS_RDATA_IDLE 8'h00
// ==========================================================
// field positions
`define XPS_FIELD_W 2
`define XPS_KEEP_MSB 3
`define XPS_KEEP_LSB 0
`define XPS_MON_BIT 6
`define XPS_SOFT_BIT 7
`define XPS_KEEP_ALL 4'hf
`define XPS_NONE 4'h0
`endif

// [rtl/xps_pkg.sv]
package xps_pkg;
   // ==========================================================
   // types
   typedef logic [1:0] xps_sel_t;
   typedef logic [7:0] xps_byte_t;
   typedef enum logic {XPS_POWER_DOWN, XPS_POWER_UP} xps_power_t;
endpackage : xps_pkg

// [rtl/xps_word_sync.sv]
`timescale 1ns/1ps
// ==========================================================
// toggle handshake carrying a word between two clocks
module xps_word_sync #(
   parameter int W = 8,
   parameter logic [W-1:0] RESET_WORD = '0
) (
   // source side
   input wire logic src_clk,
   input wire logic [W-1:0] src_word,
   output logic src_busy,
   // destination side
   input wire logic dst_clk,
   output logic [W-1:0] dst_word,
   // reset
   input wire logic resetn
);
   logic [W-1:0] sent;
   logic req_t;
   logic ack_s1;
   logic ack_s2;
   logic req_s1;
   logic req_s2;
   logic req_seen;
   wire launch = !src_busy && (src_word != sent);

   assign src_busy = req_t != ack_s2;

   // sent stays frozen while busy, so the far side samples a settled word
   always_ff @(posedge src_clk or negedge resetn) begin
      if (!resetn) begin
         sent <= RESET_WORD;
         req_t <= 1'b0;
         ack_s1 <= 1'b0;
         ack_s2 <= 1'b0;
      end else begin
         ack_s1 <= req_seen;
         ack_s2 <= ack_s1;
         if (launch) begin
            sent <= src_word;
            req_t <= ~req_t;
         end
      end
   end

   always_ff @(posedge dst_clk or negedge resetn) begin
      if (!resetn) begin
         req_s1 <= 1'b0;
         req_s2 <= 1'b0;
         req_seen <= 1'b0;
         dst_word <= RESET_WORD;
      end else begin
         req_s1 <= req_t;
         req_s2 <= req_s1;
         req_seen <= req_s2;
         if (req_s2 != req_seen) begin
            dst_word <= sent;
         end
      end
   end
endmodule : xps_word_sync

// [rtl/xps_route_power_regs.sv]
`timescale 1ns/1ps
`include "xps_map.svh"
// Behaviour
// - routing register holds four 2-bit fields, field n picks output n source, reset 00.
// - field codes 00..11 select input 0..3, upper bit most significant.
// - inputs and outputs not needed by the routing are powered down automatically.
// - control bits 3:0 keep outputs on, reset 1111; 0 powers output down.
// - monitor enable bit 6 keeps all inputs and monitors active regardless of routing.
// - soft power bit 7 is ORed with the power pin, reset 0.
// - with pin and soft bit low all shuts down except monitors and bus; the code keeps the monitors only while monitor enable bit 6 is set.
// - in power-up an output runs only if routed and its keep-on bit is 1.
// - in power-up an input runs if routing uses it or monitor enable is set; the code counts only routing to outputs whose keep-on bit is 1.
// - status bits 3:0 show one input each, 1 valid signal, 0 open; reset 0.
// - status bits 7:4 are reserved read-only and must not be relied on.
// - routing at address 0, control at 3, status at 4.
// - registers usable only with bus mode pin high; else routing from select pins.
module xps_route_power_regs (
   // core clock and reset
   input wire logic clk,
   input wire logic resetn,
   // register port on the bus clock
   input wire logic clk_link,
   input wire logic link_wr,
   input wire logic link_rd,
   input wire logic [7:0] link_addr,
   input wire logic [7:0] link_wdata,
   output logic [7:0] link_rdata,
   output logic link_ack,
   // device pins
   input wire logic hw_power_pin,
   input wire logic smb_mode_pin,
   input wire logic [7:0] pin_route,
   input wire logic input0_alive,
   input wire logic input1_alive,
   input wire logic input2_alive,
   input wire logic input3_alive,
   // power and routing controls
   output logic [3:0] output_enable,
   output logic [3:0] input_enable,
   output logic [7:0] output_route,
   output logic power_up
);
   // ==========================================================
   // decode helpers
   function automatic logic [3:0] route_hits(input xps_pkg::xps_byte_t route,
                                             input xps_pkg::xps_sel_t inp);
      logic [3:0] hits;
      hits = `XPS_NONE;
      for (int n = 0; n < 4; n++) begin
         hits[n] = route[n*2 +: 2] == inp;
      end
      return hits;
   endfunction : route_hits

   function automatic logic [3:0] inputs_used(input xps_pkg::xps_byte_t route,
                                              input logic [3:0] outs);
      logic [3:0] used;
      used = `XPS_NONE;
      for (int i = 0; i < 4; i++) begin
         used[i] = |(route_hits(route, 2'(i)) & outs);
      end
      return used;
   endfunction : inputs_used

   // ==========================================================
   // link domain: register storage
   xps_pkg::xps_byte_t routing;
   xps_pkg::xps_byte_t control;
   logic mode_l1;
   logic mode_link;
   logic [3:0] status_link;
   wire hit_route = link_addr == `XPS_ADDR_ROUTE;
   wire hit_ctrl = link_addr == `XPS_ADDR_CTRL;
   wire hit_status = link_addr == `XPS_ADDR_STATUS;
   wire mapped = hit_route || hit_ctrl || hit_status;
   wire access_ok = mode_link && mapped;
   wire wr_route = link_wr && mode_link && hit_route;
   wire wr_ctrl = link_wr && mode_link && hit_ctrl;
   wire [7:0] read_mux = hit_route ? routing :
                         hit_ctrl ? control :
                         {`XPS_RSVD_READ, status_link};
   wire [7:0] next_rdata = access_ok ? read_mux : `XPS_RDATA_IDLE;

   always_ff @(posedge clk_link or negedge resetn) begin
      if (!resetn) begin
         mode_l1 <= 1'b0;
         mode_link <= 1'b0;
      end else begin
         mode_l1 <= smb_mode_pin;
         mode_link <= mode_l1;
      end
   end

   // status writes fall through: acked, nothing stored
   always_ff @(posedge clk_link or negedge resetn) begin
      if (!resetn) begin
         routing <= `XPS_ROUTE_RESET;
         control <= `XPS_CTRL_RESET;
      end else begin
         if (wr_route) begin
            routing <= link_wdata;
         end
         if (wr_ctrl) begin
            control <= link_wdata;
         end
      end
   end

   always_ff @(posedge clk_link or negedge resetn) begin
      if (!resetn) begin
         link_rdata <= `XPS_RDATA_IDLE;
         link_ack <= 1'b0;
      end else begin
         link_rdata <= next_rdata;
         link_ack <= (link_wr || link_rd) && access_ok;
      end
   end

   // ==========================================================
   // crossings between the two clocks
   logic [15:0] regs_core;
   logic [3:0] status;

   xps_word_sync #(
      .W(16),
      .RESET_WORD({`XPS_CTRL_RESET, `XPS_ROUTE_RESET})
   ) u_regs_sync (
      .src_clk(clk_link),
      .src_word({control, routing}),
      .src_busy(),
      .dst_clk(clk),
      .dst_word(regs_core),
      .resetn(resetn)
   );

   // status may lag the monitors by a few cycles of each clock
   xps_word_sync #(
      .W(4),
      .RESET_WORD(`XPS_STATUS_RESET)
   ) u_status_sync (
      .src_clk(clk),
      .src_word(status),
      .src_busy(),
      .dst_clk(clk_link),
      .dst_word(status_link),
      .resetn(resetn)
   );

   // ==========================================================
   // core domain: pin synchronisers
   logic [13:0] pins_s1;
   logic [13:0] pins_s2;
   wire [13:0] pins_raw = {input3_alive, input2_alive, input1_alive, input0_alive,
                           pin_route, smb_mode_pin, hw_power_pin};

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pins_s1 <= 14'h0000;
         pins_s2 <= 14'h0000;
      end else begin
         pins_s1 <= pins_raw;
         pins_s2 <= pins_s1;
      end
   end

   wire hw_pwr = pins_s2[0];
   wire smb_mode = pins_s2[1];
   wire [7:0] pin_route_s = pins_s2[9:2];
   wire [3:0] alive = pins_s2[13:10];

   // ==========================================================
   // core domain: power decision
   wire [7:0] reg_route = regs_core[7:0];
   wire [7:0] reg_ctrl = regs_core[15:8];
   wire [7:0] route_now = smb_mode ? reg_route : pin_route_s;
   wire [3:0] keep_on = smb_mode ? reg_ctrl[`XPS_KEEP_MSB:`XPS_KEEP_LSB]
                                 : `XPS_KEEP_ALL;
   wire mon_en = smb_mode && reg_ctrl[`XPS_MON_BIT];
   wire soft_pwr = smb_mode && reg_ctrl[`XPS_SOFT_BIT];
   wire [3:0] mon_mask = mon_en ? `XPS_KEEP_ALL : `XPS_NONE;
   xps_pkg::xps_power_t power_now;
   logic [3:0] next_out_en;
   logic [3:0] next_in_en;

   assign power_now = (hw_pwr || soft_pwr) ? xps_pkg::XPS_POWER_UP
                                           : xps_pkg::XPS_POWER_DOWN;

   always_comb begin
      unique case (power_now)
         xps_pkg::XPS_POWER_UP: begin
            next_out_en = keep_on;
            next_in_en = inputs_used(route_now, keep_on) | mon_mask;
         end
         xps_pkg::XPS_POWER_DOWN: begin
            next_out_en = `XPS_NONE;
            next_in_en = mon_mask;
         end
      endcase
   end

   // a powered-down receiver has no monitor, so it reports open
   wire [3:0] next_status = alive & input_enable;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         output_enable <= `XPS_NONE;
         input_enable <= `XPS_NONE;
         output_route <= `XPS_ROUTE_RESET;
         power_up <= 1'b0;
         status <= `XPS_STATUS_RESET;
      end else begin
         output_enable <= next_out_en;
         input_enable <= next_in_en;
         output_route <= route_now;
         power_up <= power_now == xps_pkg::XPS_POWER_UP;
         status <= next_status;
      end
   end

   // ==========================================================
   // checks on the core clock
   default clocking core_cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   logic [3:0] dark_cnt;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         dark_cnt <= 4'h0;
      end else if (input_enable[0]) begin
         dark_cnt <= 4'h0;
      end else if (dark_cnt != 4'hf) begin
         dark_cnt <= dark_cnt + 4'h1;
      end
   end

   a_out_power_down: assert property (
      !hw_pwr && !soft_pwr |=> output_enable == `XPS_NONE && !power_up)
      else $error("outputs stay on in power down");

   a_soft_or_pin: assert property (
      hw_pwr || soft_pwr |=> power_up)
      else $error("power up not reached from pin or soft bit");

   a_out_keep_gate: assert property (
      power_now == xps_pkg::XPS_POWER_UP && !keep_on[2] |=> !output_enable[2])
      else $error("output 2 enabled with keep-on clear");

   a_out_routed_on: assert property (
      power_now == xps_pkg::XPS_POWER_UP && keep_on[1] |=> output_enable[1])
      else $error("kept output 1 not enabled in power up");

   a_in_monitor_all: assert property (
      mon_en |=> input_enable == `XPS_KEEP_ALL)
      else $error("monitor enable left an input off");

   a_in_used_on: assert property (
      power_now == xps_pkg::XPS_POWER_UP && keep_on[3]
      |=> input_enable[$past(route_now[7:6])])
      else $error("input driving output 3 is off");

   a_in_unused_off: assert property (
      !mon_en && (route_hits(route_now, 2'h2) & keep_on) == `XPS_NONE
      |=> !input_enable[2])
      else $error("unused input 2 left on");

   a_route_pin_mode: assert property (
      !smb_mode |=> output_route == $past(pin_route_s))
      else $error("pin mode routing not taken from select pins");

   a_status_dark: assert property (
      dark_cnt >= 4'h2 |-> !status[0])
      else $error("status shows signal on a powered-down input");

   a_in_down_mon: assert property (
      power_now == xps_pkg::XPS_POWER_DOWN && !mon_en |=> input_enable == `XPS_NONE)
      else $error("input left on in power down without monitor enable");

   a_out_pin_keep: assert property (
      !smb_mode && hw_pwr |=> output_enable == `XPS_KEEP_ALL)
      else $error("pin mode power up left an output off");

   a_route_bus_mode: assert property (
      smb_mode |=> output_route == $past(reg_route))
      else $error("bus mode routing not taken from register");

   a_status_live: assert property (
      alive[1] && input_enable[1] |=> status[1])
      else $error("live input 1 not shown in status");

   // ==========================================================
   // checks on the bus clock
   sequence s_write_ok(hit);
      link_wr && mode_link && hit;
   endsequence

   sequence s_write_blocked;
      link_wr && !mode_link;
   endsequence

   sequence s_read_ok(hit);
      link_rd && mode_link && hit;
   endsequence

   a_route_write: assert property (
      @(posedge clk_link) disable iff (!resetn)
      s_write_ok(hit_route) |=> routing == $past(link_wdata))
      else $error("routing write not stored");

   a_ctrl_write: assert property (
      @(posedge clk_link) disable iff (!resetn)
      s_write_ok(hit_ctrl) |=> control == $past(link_wdata))
      else $error("control write not stored");

   a_status_write_ro: assert property (
      @(posedge clk_link) disable iff (!resetn)
      s_write_ok(hit_status) |=> $stable(routing) && $stable(control) && link_ack)
      else $error("status write disturbed registers or was not acked");

   a_pin_mode_lock: assert property (
      @(posedge clk_link) disable iff (!resetn)
      s_write_blocked |=> $stable(routing) && $stable(control) && !link_ack)
      else $error("write taken in pin mode");

   a_rsvd_zero: assert property (
      @(posedge clk_link) disable iff (!resetn)
      link_rd && mode_link && hit_status |=> link_rdata[7:4] == `XPS_RSVD_READ)
      else $error("reserved status bits not zero");

   a_route_read: assert property (
      @(posedge clk_link) disable iff (!resetn)
      s_read_ok(hit_route) |=> link_ack && link_rdata == $past(routing))
      else $error("routing read returned wrong data");

   a_ctrl_read: assert property (
      @(posedge clk_link) disable iff (!resetn)
      s_read_ok(hit_ctrl) |=> link_ack && link_rdata == $past(control))
      else $error("control read returned wrong data");

   a_status_read: assert property (
      @(posedge clk_link) disable iff (!resetn)
      s_read_ok(hit_status) |=> link_ack && link_rdata[3:0] == $past(status_link))
      else $error("status read returned wrong data");

   a_unmapped_quiet: assert property (
      @(posedge clk_link) disable iff (!resetn)
      (link_wr || link_rd) && !mapped |=> !link_ack && link_rdata == `XPS_RDATA_IDLE)
      else $error("unmapped access answered");
endmodule : xps_route_power_regs

// [testbench/xps_link_host.sv]
`timescale 1ns/1ps
// ==========================================================
// bus front end driving the register port
module xps_link_host (
   // link clock and strobes
   output logic clk_link,
   output logic link_wr,
   output logic link_rd,
   output logic [7:0] link_addr,
   output logic [7:0] link_wdata,
   // answer
   input wire logic link_ack
);
   logic run = 1'b1;
   // ==========================================================
   // clock stands low between frames
   initial begin
      clk_link = 1'b0;
      link_wr = 1'b0;
      link_rd = 1'b0;
      link_addr = 8'h5a;
      link_wdata = 8'ha5;
      #1.3;
      forever #3 if (run || clk_link) clk_link = ~clk_link;
   end
   // ==========================================================
   // one access per frame, strobe, address and data all driven on the same edge
   task automatic xfer(input logic wr, input logic [7:0] addr, input logic [7:0] data);
      run = 1'b1;
      repeat (3) @(posedge clk_link);
      link_wr <= wr;
      link_rd <= ~wr;
      link_addr <= addr;
      link_wdata <= data;
      @(posedge clk_link);
      link_wr <= 1'b0;
      link_rd <= 1'b0;
      repeat (2) @(posedge clk_link);
      // released lines must not keep showing the old value
      link_addr <= ~addr;
      link_wdata <= ~data;
      // keeps clocking so the written word can cross
      repeat (12) @(posedge clk_link);
      run = 1'b0;
   endtask : xfer
endmodule : xps_link_host

// [testbench/xps_route_power_regs_test.sv]
`timescale 1ns/1ps
module xps_route_power_regs_test;
   // ==========================================================
   // signals
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic hw_power_pin = 1'b0;
   logic smb_mode_pin = 1'b1;
   logic [7:0] pin_route = 8'h00;
   logic [3:0] alive = 4'h0;
   logic clk_link, link_wr, link_rd, link_ack, power_up;
   logic [7:0] link_addr, link_wdata, link_rdata, output_route;
   logic [3:0] output_enable, input_enable;
   logic [7:0] exp_q[$];
   logic [7:0] route_val, ctrl_val;
   logic [16:0] exp_pins;
   int n_fail = 0;
   int num_checks = 0;
   int n_ack = 0;
   int exp_ack = 0;
   int cycles = 0;
   integer seed = 82291;
   always #5 clk = ~clk;
   xps_route_power_regs DUT (.clk(clk), .resetn(resetn), .clk_link(clk_link),
      .link_wr(link_wr), .link_rd(link_rd), .link_addr(link_addr), .link_wdata(link_wdata),
      .link_rdata(link_rdata), .link_ack(link_ack), .hw_power_pin(hw_power_pin),
      .smb_mode_pin(smb_mode_pin), .pin_route(pin_route), .input0_alive(alive[0]),
      .input1_alive(alive[1]), .input2_alive(alive[2]), .input3_alive(alive[3]),
      .output_enable(output_enable), .input_enable(input_enable),
      .output_route(output_route), .power_up(power_up));
   xps_link_host host (.clk_link(clk_link), .link_wr(link_wr), .link_rd(link_rd),
      .link_addr(link_addr), .link_wdata(link_wdata), .link_ack(link_ack));
   // ==========================================================
   // checking and closing
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : results
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_fail++;
         results();
      end
   end
   // oldest noted read value against each acknowledged answer while a value is noted
   always @(posedge clk_link) begin
      if (link_ack === 1'b1) begin
         n_ack++;
         if (exp_q.size() > 0) check("read data", link_rdata, exp_q.pop_front());
      end
   end
   // ==========================================================
   // bus access and expected power state
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      exp_ack++;
      host.xfer(1'b1, a, d);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_ack++;
      exp_q.push_back(e);
      host.xfer(1'b0, a, 8'h00);
   endtask : rd
   function automatic logic [16:0] model_out(input logic [7:0] rt, input logic [7:0] ct);
      logic [7:0] r;
      logic up;
      logic [3:0] keep;
      logic [3:0] ien;
      r = smb_mode_pin ? rt : pin_route;
      up = hw_power_pin | (smb_mode_pin & ct[7]);
      keep = smb_mode_pin ? ct[3:0] : 4'hf;
      ien = (smb_mode_pin & ct[6]) ? 4'hf : 4'h0;
      for (int n = 0; n < 4; n++) if (up && keep[n]) ien[r[2*n+:2]] = 1'b1;
      return {up, r, up ? keep : 4'h0, ien};
   endfunction : model_out
   task automatic check_pins();
      exp_pins = model_out(route_val, ctrl_val);
      repeat (8) @(posedge clk);
      check("power_up", {7'h00, power_up}, {7'h00, exp_pins[16]});
      check("output_route", output_route, exp_pins[15:8]);
      check("output_enable", {4'h0, output_enable}, {4'h0, exp_pins[7:4]});
      check("input_enable", {4'h0, input_enable}, {4'h0, exp_pins[3:0]});
   endtask : check_pins
   // ==========================================================
   // main sequence
   initial begin
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      repeat (4) @(posedge clk);
      route_val = 8'h00;
      ctrl_val = 8'h0f;
      check_pins();
      rd(8'h00, 8'h00);
      rd(8'h03, 8'h0f);
      rd(8'h04, 8'h00);
      host.xfer(1'b0, 8'h01, 8'h00);
      host.xfer(1'b1, 8'h02, 8'hff);
      check("unmapped acks", n_ack[7:0], exp_ack[7:0]);
      for (int i = 0; i < 8; i++) begin
         route_val = (i == 0) ? 8'he4 : 8'($random(seed));
         ctrl_val = (i == 1) ? 8'h4a : 8'($random(seed));
         @(posedge clk);
         hw_power_pin <= (i == 1) ? 1'b0 : 1'($random(seed));
         alive <= 4'($random(seed));
         wr(8'h00, route_val);
         wr(8'h03, ctrl_val);
         wr(8'h04, 8'hff);
         check_pins();
         rd(8'h00, route_val);
         rd(8'h03, ctrl_val);
         // first status read after idle may be stale
         exp_ack++;
         host.xfer(1'b0, 8'h04, 8'h00);
         rd(8'h04, {4'h0, alive & exp_pins[3:0]});
      end
      @(posedge clk);
      smb_mode_pin <= 1'b0;
      pin_route <= 8'($random(seed));
      @(posedge clk);
      check_pins();
      host.xfer(1'b0, 8'h00, 8'h00);
      host.xfer(1'b1, 8'h00, ~route_val);
      check("pin mode acks", n_ack[7:0], exp_ack[7:0]);
      @(posedge clk);
      smb_mode_pin <= 1'b1;
      rd(8'h00, route_val);
      check("pending reads", 8'(exp_q.size()), 8'h00);
      check("total acks", n_ack[7:0], exp_ack[7:0]);
      results();
   end
endmodule : xps_route_power_regs_test
